// >>> design/citd_pkg.sv
package citd_pkg;
  // register space offsets and reset values
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_PTR_LOW = 8'h00;
  localparam logic [7:0] RST_PTR_HIGH = 8'h00;
  // direct addresses with this bit set reach the register space
  localparam int SPECIAL_BIT = 7;
  // cycle counts and range spreads
  localparam logic [3:0] CYC1 = 4'h1, CYC2 = 4'h2, CYC3 = 4'h3;
  localparam logic [3:0] CYC4 = 4'h4, CYC5 = 4'h5, CYC6 = 4'h6;
  localparam logic [1:0] SPAN2 = 2'h2, SPAN3 = 2'h3;
  // stack steps for one byte and for a return address
  localparam logic [7:0] STK_ONE = 8'h01, STK_TWO = 8'h02;
  // single opcodes
  localparam logic [7:0] OP_NOP = 8'h00, OP_SPARE = 8'ha5;
  localparam logic [7:0] OP_ANL_DI = 8'h53, OP_ORL_DI = 8'h43;
  localparam logic [7:0] OP_XRL_DI = 8'h63, OP_CLR_A = 8'he4;
  localparam logic [7:0] OP_CPL_A = 8'hf4, OP_RL_A = 8'h23;
  localparam logic [7:0] OP_RLC_A = 8'h33, OP_RR_A = 8'h03;
  localparam logic [7:0] OP_RRC_A = 8'h13, OP_SWAP_A = 8'hc4;
  localparam logic [7:0] OP_MOV_DD = 8'h85, OP_LOAD_PTR = 8'h90;
  localparam logic [7:0] OP_CODE_PTR = 8'h93, OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_XRD_PTR = 8'he0, OP_XWR_PTR = 8'hf0;
  localparam logic [7:0] OP_PUSH = 8'hc0, OP_POP = 8'hd0;
  localparam logic [7:0] OP_CLR_C = 8'hc3, OP_SET_C = 8'hd3;
  localparam logic [7:0] OP_CPL_C = 8'hb3, OP_CLR_B = 8'hc2;
  localparam logic [7:0] OP_SET_B = 8'hd2, OP_CPL_B = 8'hb2;
  localparam logic [7:0] OP_ANL_CB = 8'h82, OP_ANL_CNB = 8'hb0;
  localparam logic [7:0] OP_ORL_CB = 8'h72, OP_ORL_CNB = 8'ha0;
  localparam logic [7:0] OP_MOV_CB = 8'ha2, OP_MOV_BC = 8'h92;
  localparam logic [7:0] OP_JC = 8'h40, OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60, OP_JNZ = 8'h70;
  localparam logic [7:0] OP_JB = 8'h20, OP_JNB = 8'h30;
  localparam logic [7:0] OP_JB_CLR = 8'h10, OP_LCALL = 8'h12;
  localparam logic [7:0] OP_LJMP = 8'h02, OP_RET = 8'h22;
  localparam logic [7:0] OP_RETI = 8'h32, OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JMP_IND = 8'h73, OP_CMPJ_AD = 8'hb5;
  localparam logic [7:0] OP_CMPJ_AI = 8'hb4, OP_DECJ_D = 8'hd5;
  // opcode groups: top five bits for register forms
  localparam logic [4:0] G_MOV_A_REG = 5'h1d, G_MOV_REG_A = 5'h1f;
  localparam logic [4:0] G_CMPJ_REG = 5'h17, G_DECJ_REG = 5'h1b;
  // top seven bits for indirect forms
  localparam logic [6:0] G_MOV_A_IND = 7'h73, G_MOV_IND_A = 7'h7b;
  localparam logic [6:0] G_XRD_IND = 7'h71, G_XWR_IND = 7'h79;
  localparam logic [6:0] G_CMPJ_IND = 7'h5b;
  // low five bits of the page jump and page call
  localparam logic [4:0] LOW_AJMP = 5'h01, LOW_ACALL = 5'h11;
  // low opcode bits that mark an indirect operand
  localparam logic [2:0] IND_LOW = 3'h3;
endpackage

// >>> design/citd_core.sv
// Notes on behaviour
// - logic op of immediate into direct byte takes three cycles
// - clear, rotates, swap of accumulator one cycle; complement two
// - register to accumulator moves one cycle, indirect moves two
// - direct to direct move takes three cycles
// - pointer load from 16-bit constant takes three cycles
// - code read via pointer four to seven cycles, via pc three
// - external data reads and writes take three cycles
// - push and pop of direct byte take two cycles
// - carry ops one cycle, addressed bit ops two cycles
// - carry or zero jumps: two not taken, four to six taken
// - bit jumps three or five to seven; clear variant clears set bit
// - page/short jumps 4-6, long 5-7, returns 6-8 cycles
// - indirect jump via accumulator plus pointer three to five cycles
// - compare-jump: three or four not taken, five to eight taken
// - decrement-jump: two or three not taken, four to seven taken
// - register operand picks R0-R7 of bank; indirect uses R0 or R1
// - relative target is next address plus signed 8-bit offset
// - direct address below 0x80 is RAM, above is register space
// - page target keeps 2 kB page of the following instruction
// - long target reaches any of 64 kB program space
// - spare opcode 0xa5 behaves as one-cycle no-operation
// - 16-bit pointer built from low and high byte registers
// - stack pointer resets to 0x07, incremented before push stores
// - branches not taken finish sooner than when taken
module citd_core import citd_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] nextPc,
  input wire logic [1:0] bankSel,
  input wire logic [7:0] accValue,
  input wire logic carryFlag,
  input wire logic bitValue,
  input wire logic [7:0] operandValue,
  input wire logic [15:0] retAddr,
  input wire logic [1:0] prefetchAlign,
  input wire logic [7:0] regBusAddr,
  input wire logic regBusWrEn,
  input wire logic [7:0] regBusWrData,
  output logic [7:0] regBusRdData,
  output logic instrReady,
  output logic instrDone,
  output logic [3:0] cycleCount,
  output logic branchTaken,
  output logic [15:0] branchTarget,
  output logic [15:0] codeAddr,
  output logic [4:0] regAddr,
  output logic regIndirect,
  output logic [7:0] directAddr,
  output logic directIsSpecial,
  output logic bitClearReq,
  output logic [7:0] stackAddr,
  output logic stackWrite,
  output logic stackRead,
  output logic [15:0] codeDataPointer
);

  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic ready;
    logic done;
    logic [3:0] cycles;
    logic taken;
    logic [15:0] target;
    logic [15:0] codeAddr;
    logic [4:0] regAddr;
    logic regInd;
    logic [7:0] dirAddr;
    logic dirSpecial;
    logic bitClr;
    logic [7:0] stkAddr;
    logic stkWr;
    logic stkRd;
    logic [7:0] pointerLowByte;
    logic [7:0] pointerHighByte;
    logic [7:0] stackTopPtr;
    logic [7:0] rdData;
  } citd_state_type;

  citd_state_type st_q;
  citd_state_type st_d;
  logic accept;
  logic [3:0] cyc;
  logic tkn;
  logic [15:0] relOne;
  logic [15:0] relTwo;
  logic [15:0] pageTgt;
  logic [15:0] ptrWord;
  logic [15:0] accPlusPtr;

  // count inside a range chosen by prefetch alignment, capped at the top
  function automatic logic [3:0] pick(input logic [3:0] lo,
                                      input logic [1:0] span,
                                      input logic [1:0] align);
    logic [1:0] step;
    step = (align > span) ? span : align;
    pick = lo + {2'b00, step};
  endfunction

  // not-taken count or ranged taken count
  function automatic logic [3:0] brCyc(input logic cond,
                                       input logic [3:0] nt,
                                       input logic [3:0] lo,
                                       input logic [1:0] align);
    brCyc = cond ? pick(lo, SPAN2, align) : nt;
  endfunction

  // branch target candidates
  assign ptrWord = {st_q.pointerHighByte, st_q.pointerLowByte};
  assign accPlusPtr = ptrWord + {8'h00, accValue};
  assign relOne = nextPc + {{8{operand1[7]}}, operand1};
  assign relTwo = nextPc + {{8{operand2[7]}}, operand2};
  assign pageTgt = {nextPc[15:11], opcode[7:5], operand1};
  assign accept = instrValid && st_q.ready;

  // next state: sequencing, decode, register access, reset
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.bitClr = 1'b0;
    st_d.stkWr = 1'b0;
    st_d.stkRd = 1'b0;
    cyc = CYC1;
    tkn = 1'b0;
    // count down the instruction in flight
    if (st_q.busy) begin
      if (st_q.cnt == 4'h0) begin
        st_d.busy = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 4'h1;
        st_d.done = (st_q.cnt == 4'h1);
      end
    end
    // register space writes
    if (regBusWrEn) begin
      case (regBusAddr)
        ADDR_PTR_LOW: st_d.pointerLowByte = regBusWrData;
        ADDR_PTR_HIGH: st_d.pointerHighByte = regBusWrData;
        ADDR_STACK_TOP: st_d.stackTopPtr = regBusWrData;
        default: ;
      endcase
    end
    // register space reads, one cycle later, unmapped reads zero
    case (regBusAddr)
      ADDR_PTR_LOW: st_d.rdData = st_q.pointerLowByte;
      ADDR_PTR_HIGH: st_d.rdData = st_q.pointerHighByte;
      ADDR_STACK_TOP: st_d.rdData = st_q.stackTopPtr;
      default: st_d.rdData = 8'h00;
    endcase
    if (accept) begin
      // operand decode
      st_d.regInd = (opcode[3:1] == IND_LOW);
      if (opcode[3:1] == IND_LOW) begin
        st_d.regAddr = {bankSel, 2'b00, opcode[0]};
      end else begin
        st_d.regAddr = {bankSel, opcode[2:0]};
      end
      st_d.dirAddr = operand1;
      st_d.dirSpecial = operand1[SPECIAL_BIT];
      st_d.target = nextPc;
      st_d.codeAddr = ptrWord;
      case (opcode)
        OP_NOP, OP_SPARE: cyc = CYC1;
        OP_ANL_DI, OP_ORL_DI, OP_XRL_DI: cyc = CYC3;
        OP_CLR_A, OP_RL_A, OP_RLC_A: cyc = CYC1;
        OP_RR_A, OP_RRC_A, OP_SWAP_A: cyc = CYC1;
        OP_CPL_A: cyc = CYC2;
        OP_MOV_DD: begin
          cyc = CYC3;
          st_d.dirAddr = operand2;
          st_d.dirSpecial = operand2[SPECIAL_BIT];
        end
        OP_LOAD_PTR: begin
          cyc = CYC3;
          st_d.pointerHighByte = operand1;
          st_d.pointerLowByte = operand2;
        end
        OP_CODE_PTR: begin
          cyc = pick(CYC4, SPAN3, prefetchAlign);
          st_d.codeAddr = accPlusPtr;
        end
        OP_CODE_PC: begin
          cyc = CYC3;
          st_d.codeAddr = nextPc + {8'h00, accValue};
        end
        OP_XRD_PTR, OP_XWR_PTR: cyc = CYC3;
        OP_PUSH: begin
          cyc = CYC2;
          st_d.stackTopPtr = st_q.stackTopPtr + STK_ONE;
          st_d.stkAddr = st_q.stackTopPtr + STK_ONE;
          st_d.stkWr = 1'b1;
        end
        OP_POP: begin
          cyc = CYC2;
          st_d.stkAddr = st_q.stackTopPtr;
          st_d.stackTopPtr = st_q.stackTopPtr - STK_ONE;
          st_d.stkRd = 1'b1;
        end
        OP_CLR_C, OP_SET_C, OP_CPL_C: cyc = CYC1;
        OP_CLR_B, OP_SET_B, OP_CPL_B, OP_ANL_CB, OP_ANL_CNB,
        OP_ORL_CB, OP_ORL_CNB, OP_MOV_CB, OP_MOV_BC: begin
          cyc = CYC2;
        end
        OP_JC, OP_JNC, OP_JZ, OP_JNZ: begin
          case (opcode)
            OP_JC: tkn = carryFlag;
            OP_JNC: tkn = !carryFlag;
            OP_JZ: tkn = (accValue == 8'h00);
            default: tkn = (accValue != 8'h00);
          endcase
          cyc = brCyc(tkn, CYC2, CYC4, prefetchAlign);
          st_d.target = relOne;
        end
        OP_JB, OP_JNB, OP_JB_CLR: begin
          tkn = (opcode == OP_JNB) ? !bitValue : bitValue;
          cyc = brCyc(tkn, CYC3, CYC5, prefetchAlign);
          st_d.bitClr = (opcode == OP_JB_CLR) && bitValue;
          st_d.target = relTwo;
        end
        OP_LCALL, OP_LJMP: begin
          tkn = 1'b1;
          cyc = pick(CYC5, SPAN2, prefetchAlign);
          st_d.target = {operand1, operand2};
          if (opcode == OP_LCALL) begin
            st_d.stackTopPtr = st_q.stackTopPtr + STK_TWO;
            st_d.stkAddr = st_q.stackTopPtr + STK_ONE;
            st_d.stkWr = 1'b1;
          end
        end
        OP_RET, OP_RETI: begin
          tkn = 1'b1;
          cyc = pick(CYC6, SPAN2, prefetchAlign);
          st_d.target = retAddr;
          st_d.stkAddr = st_q.stackTopPtr;
          st_d.stackTopPtr = st_q.stackTopPtr - STK_TWO;
          st_d.stkRd = 1'b1;
        end
        OP_SJMP: begin
          tkn = 1'b1;
          cyc = pick(CYC4, SPAN2, prefetchAlign);
          st_d.target = relOne;
        end
        OP_JMP_IND: begin
          tkn = 1'b1;
          cyc = pick(CYC3, SPAN2, prefetchAlign);
          st_d.target = accPlusPtr;
        end
        OP_CMPJ_AD, OP_CMPJ_AI: begin
          if (opcode == OP_CMPJ_AD) begin
            tkn = (accValue != operandValue);
            cyc = brCyc(tkn, CYC4, CYC6, prefetchAlign);
          end else begin
            tkn = (accValue != operand1);
            cyc = brCyc(tkn, CYC3, CYC6, prefetchAlign);
          end
          st_d.target = relTwo;
        end
        OP_DECJ_D: begin
          tkn = (operandValue != STK_ONE);
          cyc = brCyc(tkn, CYC3, CYC5, prefetchAlign);
          st_d.target = relTwo;
        end
        default: begin
          if (opcode[7:3] == G_MOV_A_REG || opcode[7:3] == G_MOV_REG_A) begin
            cyc = CYC1;
          end else if (opcode[7:1] == G_MOV_A_IND ||
                       opcode[7:1] == G_MOV_IND_A) begin
            cyc = CYC2;
          end else if (opcode[7:1] == G_XRD_IND ||
                       opcode[7:1] == G_XWR_IND) begin
            cyc = CYC3;
          end else if (opcode[7:3] == G_CMPJ_REG) begin
            tkn = (operandValue != operand1);
            cyc = brCyc(tkn, CYC3, CYC5, prefetchAlign);
            st_d.target = relTwo;
          end else if (opcode[7:1] == G_CMPJ_IND) begin
            tkn = (operandValue != operand1);
            cyc = brCyc(tkn, CYC4, CYC6, prefetchAlign);
            st_d.target = relTwo;
          end else if (opcode[7:3] == G_DECJ_REG) begin
            tkn = (operandValue != STK_ONE);
            cyc = brCyc(tkn, CYC2, CYC4, prefetchAlign);
            st_d.target = relOne;
          end else if (opcode[4:0] == LOW_AJMP ||
                       opcode[4:0] == LOW_ACALL) begin
            tkn = 1'b1;
            cyc = pick(CYC4, SPAN2, prefetchAlign);
            st_d.target = pageTgt;
            if (opcode[4:0] == LOW_ACALL) begin
              st_d.stackTopPtr = st_q.stackTopPtr + STK_TWO;
              st_d.stkAddr = st_q.stackTopPtr + STK_ONE;
              st_d.stkWr = 1'b1;
            end
          end else begin
            cyc = CYC1;
          end
        end
      endcase
      st_d.busy = 1'b1;
      st_d.cnt = cyc - 4'h1;
      st_d.done = (cyc == CYC1);
      st_d.cycles = cyc;
      st_d.taken = tkn;
    end
    st_d.ready = !st_d.busy || (st_d.cnt == 4'h0);
    // synchronous reset
    if (sys_rst) begin
      st_d = '0;
      st_d.ready = 1'b1;
      st_d.stackTopPtr = RST_STACK_TOP;
      st_d.pointerLowByte = RST_PTR_LOW;
      st_d.pointerHighByte = RST_PTR_HIGH;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // outputs straight from the state register
  assign regBusRdData = st_q.rdData;
  assign instrReady = st_q.ready;
  assign instrDone = st_q.done;
  assign cycleCount = st_q.cycles;
  assign branchTaken = st_q.taken;
  assign branchTarget = st_q.target;
  assign codeAddr = st_q.codeAddr;
  assign regAddr = st_q.regAddr;
  assign regIndirect = st_q.regInd;
  assign directAddr = st_q.dirAddr;
  assign directIsSpecial = st_q.dirSpecial;
  assign bitClearReq = st_q.bitClr;
  assign stackAddr = st_q.stkAddr;
  assign stackWrite = st_q.stkWr;
  assign stackRead = st_q.stkRd;
  assign codeDataPointer = ptrWord;

  // checks on timing and decode
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_stack_reset: assert property (
    $past(sys_rst) |-> st_q.stackTopPtr == RST_STACK_TOP)
    else $error("stack pointer not at reset value");
  a_pointer_reset: assert property (
    $past(sys_rst) |-> codeDataPointer == 16'h0000)
    else $error("data pointer not cleared by reset");
  a_spare_nop: assert property (
    accept && (opcode == OP_SPARE) |=> instrDone && instrReady)
    else $error("spare opcode not one cycle");
  a_move_three: assert property (
    accept && (opcode == OP_MOV_DD) |=> !instrDone ##1 !instrDone
    ##1 instrDone)
    else $error("direct move not three cycles");
  a_carry_jump: assert property (
    accept && (opcode == OP_JC) && !carryFlag |=> !instrDone ##1
    (instrDone && !branchTaken))
    else $error("untaken carry jump not two cycles");
  a_taken_range: assert property (
    accept && (opcode == OP_JC) && carryFlag |=> branchTaken &&
    cycleCount >= CYC4 && cycleCount <= CYC6)
    else $error("taken carry jump count out of range");
  a_push_order: assert property (
    accept && (opcode == OP_PUSH) |=> stackWrite &&
    stackAddr == $past(st_q.stackTopPtr) + STK_ONE &&
    st_q.stackTopPtr == stackAddr)
    else $error("push did not increment before store");
  a_page_keep: assert property (
    accept && (opcode[4:0] == LOW_AJMP) |=>
    branchTarget[15:11] == $past(nextPc[15:11]))
    else $error("page jump left its page");
  a_rel_target: assert property (
    accept && (opcode == OP_SJMP) |=> branchTarget ==
    $past(nextPc) + 16'($signed($past(operand1))))
    else $error("relative target wrong");
  a_special_sel: assert property (
    accept && (opcode == OP_ANL_DI) |=> directAddr == $past(operand1) &&
    directIsSpecial == ($past(operand1) >= 8'h80))
    else $error("direct address space select wrong");
  a_ind_reg: assert property (
    regIndirect |-> regAddr[2:1] == 2'b00)
    else $error("indirect operand not R0 or R1");

  c_taken_jump: cover property (accept && opcode == OP_JB && bitValue);
  c_code_read: cover property (accept && opcode == OP_CODE_PTR);
  c_back_to_back: cover property (instrDone && accept);
  c_pointer_load: cover property (accept && opcode == OP_LOAD_PTR);

endmodule

// >>> test/citd_flash_model.sv
// program store: hands the decoder whole instructions, one slot each
module citd_flash_model (
  input wire logic [4:0] slot,
  output logic [7:0] opcode,
  output logic [7:0] operand1,
  output logic [7:0] operand2,
  output logic [15:0] nextPc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] code;
  // all three bytes are presented together; unused bytes read zero
  always_comb begin
    case (slot)
      5'd0: code = 24'h53200f;
      5'd1: code = 24'he40000;
      5'd2: code = 24'hf40000;
      5'd3: code = 24'h230000;
      5'd4: code = 24'hc40000;
      5'd5: code = 24'heb0000;
      5'd6: code = 24'he70000;
      5'd7: code = 24'h853090;
      5'd8: code = 24'h90abcd;
      5'd9: code = 24'h930000;
      5'd10: code = 24'h830000;
      5'd11: code = 24'he00000;
      5'd12: code = 24'hf20000;
      5'd13: code = 24'hc09000;
      5'd14: code = 24'hc30000;
      5'd15: code = 24'hb22200;
      5'd16: code = 24'h40fe00;
      5'd17: code = 24'h40fe00;
      5'd18: code = 24'h1020fe;
      5'd19: code = 24'he15500;
      5'd20: code = 24'h02ff00;
      5'd21: code = 24'h220000;
      5'd22: code = 24'h730000;
      5'd23: code = 24'hb54005;
      5'd24: code = 24'hb54005;
      5'd25: code = 24'hd80300;
      5'd26: code = 24'hd540fd;
      5'd28: code = 24'h80f000;
      default: code = 24'ha50000;
    endcase
    {opcode, operand1, operand2} = code;
    nextPc = 16'h1234;
  end
endmodule

// >>> test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] al;
    logic cy;
    logic bt;
    logic [7:0] acc;
    logic [7:0] val;
    logic [3:0] cyc;
    logic tk;
    logic [15:0] tgt;
  } citd_case_type;
  citd_case_type cases [29];
  logic mclk = 0, sys_rst = 1, instrValid = 0, carryFlag = 0, bitValue = 0;
  logic regBusWrEn = 0;
  logic [1:0] bankSel = 2'h2, prefetchAlign = 2'h0;
  logic [4:0] slot = 5'h0, regAddr;
  logic [7:0] opcode, operand1, operand2, regBusRdData, directAddr, stackAddr;
  logic [7:0] accValue = 8'h00, operandValue = 8'h00, regBusAddr = 8'h00;
  logic [7:0] regBusWrData = 8'h00;
  logic [15:0] nextPc, branchTarget, codeAddr, codeDataPointer;
  logic [15:0] retAddr = 16'h4321;
  logic [3:0] cycleCount;
  logic instrReady, instrDone, branchTaken, regIndirect, directIsSpecial;
  logic bitClearReq, stackWrite, stackRead;
  int err_count = 0, cmp_count = 0, clrCnt = 0, wrCnt = 0, rdCnt = 0;
  citd_flash_model flash (.slot(slot), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .nextPc(nextPc));
  citd_core dut (.mclk(mclk), .sys_rst(sys_rst), .instrValid(instrValid),
    .opcode(opcode), .operand1(operand1), .operand2(operand2),
    .nextPc(nextPc), .bankSel(bankSel), .accValue(accValue),
    .carryFlag(carryFlag), .bitValue(bitValue), .operandValue(operandValue),
    .retAddr(retAddr), .prefetchAlign(prefetchAlign),
    .regBusAddr(regBusAddr), .regBusWrEn(regBusWrEn),
    .regBusWrData(regBusWrData), .regBusRdData(regBusRdData),
    .instrReady(instrReady), .instrDone(instrDone),
    .cycleCount(cycleCount), .branchTaken(branchTaken),
    .branchTarget(branchTarget), .codeAddr(codeAddr), .regAddr(regAddr),
    .regIndirect(regIndirect), .directAddr(directAddr),
    .directIsSpecial(directIsSpecial), .bitClearReq(bitClearReq),
    .stackAddr(stackAddr), .stackWrite(stackWrite), .stackRead(stackRead),
    .codeDataPointer(codeDataPointer));
  // clock and pulse counters
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    if (bitClearReq === 1'b1) clrCnt++;
    if (stackWrite === 1'b1) wrCnt++;
    if (stackRead === 1'b1) rdCnt++;
  end
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // register space access: write strobe one cycle, read data one cycle late
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regBusAddr = a;
    regBusWrData = d;
    regBusWrEn = 1;
    @(posedge mclk);
    #1 regBusWrEn = 0;
    // one idle edge so a following write never re-raises the strobe at once
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    regBusAddr = a;
    @(posedge mclk);
    #1 chk(nm, {8'h00, e}, {8'h00, regBusRdData});
  endtask
  // one instruction: take edge, then count cycles until the done pulse
  task automatic exec(input int i);
    int n;
    citd_case_type c;
    c = cases[i];
    slot = i[4:0];
    {prefetchAlign, carryFlag, bitValue} = {c.al, c.cy, c.bt};
    {accValue, operandValue} = {c.acc, c.val};
    instrValid = 1;
    @(posedge mclk);
    #1;
    n = 1;
    while (instrDone !== 1'b1 && n < 12) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("cycles", {12'h000, c.cyc}, 16'(n));
    chk("cycleCount", {12'h000, c.cyc}, {12'h000, cycleCount});
    chk("taken", {15'h0000, c.tk}, {15'h0000, branchTaken});
    chk("target", c.tgt, branchTarget);
    chk("ready", 16'h0001, {15'h0000, instrReady});
  endtask
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    cases[0] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd3, 0, 16'h1234};
    cases[1] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd1, 0, 16'h1234};
    cases[2] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd2, 0, 16'h1234};
    cases[3] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd1, 0, 16'h1234};
    cases[4] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd1, 0, 16'h1234};
    cases[5] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd1, 0, 16'h1234};
    cases[6] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd2, 0, 16'h1234};
    cases[7] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd3, 0, 16'h1234};
    cases[8] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd3, 0, 16'h1234};
    cases[9] = '{2'd3, 0, 0, 8'h00, 8'h00, 4'd7, 0, 16'h1234};
    cases[10] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd3, 0, 16'h1234};
    cases[11] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd3, 0, 16'h1234};
    cases[12] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd3, 0, 16'h1234};
    cases[13] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd2, 0, 16'h1234};
    cases[14] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd1, 0, 16'h1234};
    cases[15] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd2, 0, 16'h1234};
    cases[16] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd2, 0, 16'h1232};
    cases[17] = '{2'd0, 1, 0, 8'h00, 8'h00, 4'd4, 1, 16'h1232};
    cases[18] = '{2'd2, 0, 1, 8'h00, 8'h00, 4'd7, 1, 16'h1232};
    cases[19] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd4, 1, 16'h1755};
    cases[20] = '{2'd1, 0, 0, 8'h00, 8'h00, 4'd6, 1, 16'hff00};
    cases[21] = '{2'd3, 0, 0, 8'h00, 8'h00, 4'd8, 1, 16'h4321};
    cases[22] = '{2'd2, 0, 0, 8'h10, 8'h00, 4'd5, 1, 16'habdd};
    cases[23] = '{2'd0, 0, 0, 8'h07, 8'h07, 4'd4, 0, 16'h1239};
    cases[24] = '{2'd0, 0, 0, 8'h07, 8'h08, 4'd6, 1, 16'h1239};
    cases[25] = '{2'd0, 0, 0, 8'h00, 8'h01, 4'd2, 0, 16'h1237};
    cases[26] = '{2'd0, 0, 0, 8'h00, 8'h05, 4'd5, 1, 16'h1231};
    cases[27] = '{2'd0, 0, 0, 8'h00, 8'h00, 4'd1, 0, 16'h1234};
    cases[28] = '{2'd1, 0, 0, 8'h00, 8'h00, 4'd5, 1, 16'h1224};
    repeat (3) @(posedge mclk);
    #1 sys_rst = 0;
    rd(8'h82, 8'h00, "ptrLow");
    rd(8'h83, 8'h00, "ptrHigh");
    rd(8'h81, 8'h07, "stackTop");
    wr(8'h82, 8'h5a);
    wr(8'h83, 8'ha5);
    rd(8'h82, 8'h5a, "ptrLow");
    rd(8'h83, 8'ha5, "ptrHigh");
    chk("pointer", 16'ha55a, codeDataPointer);
    rd(8'h84, 8'h00, "unmapped");
    // instruction walk, back to back, with operand decode checks
    for (int i = 0; i < 29; i++) begin
      exec(i);
      case (i)
        0: chk("special", 16'h0000, {15'h0, directIsSpecial});
        5: chk("regAddr", 16'h0013, {11'h0, regAddr});
        6: chk("indirect", 16'h1011,
               {3'h0, regIndirect, 7'h0, regAddr});
        7: chk("direct", 16'h0190, {7'h0, directIsSpecial, directAddr});
        8: chk("pointer", 16'habcd, codeDataPointer);
        9: chk("codeAddr", 16'habcd, codeAddr);
        13: chk("stackAddr", 16'h0008, {8'h00, stackAddr});
        14: chk("stackWrite", 16'h0001, 16'(wrCnt));
        19: chk("bitClear", 16'h0001, 16'(clrCnt));
        21: chk("stackAddr", 16'h0008, {8'h00, stackAddr});
        22: chk("stackRead", 16'h0001, 16'(rdCnt));
        default: ;
      endcase
    end
    instrValid = 0;
    rd(8'h81, 8'h06, "stackTop");
    test_done();
  end
endmodule
